/* File: src/wwd_defines.svh */
`ifndef WWD_DEFINES_SVH
`define WWD_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define WWD_OFS_CTRL       8'h00
`define WWD_OFS_STAT       8'h01

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WWD_WIN_MSB        7
`define WWD_WIN_LSB        4
`define WWD_PER_MSB        3
`define WWD_PER_LSB        0
`define WWD_LOCK_BIT       7
`define WWD_BUSY_BIT       0

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define WWD_STAT_RESET     8'h00
`define WWD_RDATA_IDLE     8'h00
`define WWD_CODE_OFF       4'h0
`define WWD_CODE_MAX       4'hB

// ----------------------------------------
// Timing: tick rate in Hz, lengths in watchdog ticks
// ----------------------------------------
`define WWD_TICK_HZ        1024
`define WWD_BASE_TICKS     14'h0008
`define WWD_CLR_SYNC_TICKS 2'h3
`define WWD_CFG_SYNC_TICKS 2'h2

`endif

/* File: src/wwd_pkg.sv */
package wwd_pkg;

  typedef enum logic [1:0] {
    WWD_ST_OFF    = 2'b00,
    WWD_ST_RUN    = 2'b01,
    WWD_ST_CLOSED = 2'b10,
    WWD_ST_OPEN   = 2'b11
  } wwd_state_t;

  typedef logic [13:0] wwd_cnt_t;
  typedef logic [3:0]  wwd_code_t;
  typedef logic [7:0]  wwd_byte_t;

endpackage

/* File: src/wwd_sync2.sv */
`timescale 1ns/1ps

module wwd_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;

  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule // wwd_sync2

/* File: src/wwd_top.sv */
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "wwd_defines.svh"


module wwd_top
  import wwd_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             watchdog_tick_clock,
  input  wire logic [7:0]       reg_addr,
  input  wire wwd_pkg::wwd_byte_t reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output wwd_pkg::wwd_byte_t    reg_rdata,
  input  wire logic             io_unlock_key,
  input  wire logic             watchdog_clear_instruction,
  input  wire logic             dbg_halt,
  input  wire logic             dbg_mode,
  input  wire wwd_pkg::wwd_byte_t fuse_watchdog_config,
  output logic                  sys_reset_req
);
  import wwd_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic       tick_s;
  logic       tick_last_q;
  logic       tick;
  wwd_byte_t  ctrl_q;
  wwd_byte_t  act_q;
  logic       lock_q;
  logic       busy_q;
  logic [1:0] cfg_cnt_q;
  logic       cfg_apply;
  logic       clr_pend_q;
  logic [1:0] clr_cnt_q;
  logic       clr_eff;
  logic       sel_ctrl;
  logic       sel_stat;
  logic       wr_ctrl_ok;
  logic       wr_stat_ok;
  wwd_cnt_t   per_len;
  wwd_cnt_t   win_len;
  logic       enabled;
  logic       win_mode;
  wwd_state_t st_q;
  wwd_cnt_t   cnt_q;
  wwd_byte_t  rd_mux;

  // ----------------------------------------
  // Time-out length decode
  // ----------------------------------------
  function automatic wwd_cnt_t len_of(input wwd_code_t code);
    wwd_cnt_t res;
    res = '0;
    if (code != `WWD_CODE_OFF && code <= `WWD_CODE_MAX) begin
      res = wwd_cnt_t'(`WWD_BASE_TICKS << (code - 4'h1));
    end
    return res;
  endfunction

  assign per_len  = len_of(act_q[`WWD_PER_MSB:`WWD_PER_LSB]);
  assign win_len  = len_of(act_q[`WWD_WIN_MSB:`WWD_WIN_LSB]);
  assign enabled  = (per_len != '0);
  assign win_mode = (win_len != '0);

  // ----------------------------------------
  // Watchdog tick
  // ----------------------------------------
  wwd_sync2 #(
    .W (1)
  ) u_tick_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (watchdog_tick_clock),
    .dout    (tick_s)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tick_last_q <= 1'b0;
    end else begin
      tick_last_q <= tick_s;
    end
  end

  // One pulse per rising oscillator edge, after the two-stage synchroniser
  assign tick = tick_s & ~tick_last_q;

  // ----------------------------------------
  // Register access decode
  // ----------------------------------------
  assign sel_ctrl   = (reg_addr == `WWD_OFS_CTRL);
  assign sel_stat   = (reg_addr == `WWD_OFS_STAT);
  assign wr_ctrl_ok = reg_wr && sel_ctrl && io_unlock_key && !lock_q && !busy_q;
  assign wr_stat_ok = reg_wr && sel_stat && io_unlock_key;

  // ----------------------------------------
  // Control register shadow
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= fuse_watchdog_config;
    end else if (wr_ctrl_ok) begin
      ctrl_q <= reg_wdata;
    end
  end

  // ----------------------------------------
  // Lock bit
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lock_q <= |fuse_watchdog_config[`WWD_PER_MSB:`WWD_PER_LSB];
    end else if (wr_stat_ok) begin
      if (reg_wdata[`WWD_LOCK_BIT]) begin
        lock_q <= 1'b1;
      end else if (dbg_mode) begin
        lock_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Transfer into the tick domain
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_q    <= 1'b0;
      cfg_cnt_q <= 2'h0;
    end else if (wr_ctrl_ok) begin
      busy_q    <= 1'b1;
      cfg_cnt_q <= 2'h0;
    end else if (busy_q && tick) begin
      cfg_cnt_q <= cfg_cnt_q + 2'h1;
      if (cfg_cnt_q == `WWD_CFG_SYNC_TICKS - 2'h1) begin
        busy_q <= 1'b0;
      end
    end
  end

  assign cfg_apply = busy_q && tick && (cfg_cnt_q == `WWD_CFG_SYNC_TICKS - 2'h1);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      act_q <= fuse_watchdog_config;
    end else if (cfg_apply) begin
      act_q <= ctrl_q;
    end
  end

  // ----------------------------------------
  // Clear instruction synchronisation
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clr_pend_q <= 1'b0;
      clr_cnt_q  <= 2'h0;
    end else if (clr_eff) begin
      clr_pend_q <= 1'b0;
      clr_cnt_q  <= 2'h0;
    end else if (watchdog_clear_instruction && !clr_pend_q) begin
      clr_pend_q <= 1'b1;
      clr_cnt_q  <= 2'h0;
    end else if (clr_pend_q && tick) begin
      clr_cnt_q <= clr_cnt_q + 2'h1;
    end
  end

  // Acts on the third tick edge: two to three tick periods after arrival
  assign clr_eff = clr_pend_q && tick && (clr_cnt_q == `WWD_CLR_SYNC_TICKS - 2'h1);

  // ----------------------------------------
  // Watchdog sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q          <= WWD_ST_OFF;
      cnt_q         <= '0;
      sys_reset_req <= 1'b0;
    end else begin
      sys_reset_req <= 1'b0;
      if (dbg_halt) begin
        cnt_q <= '0;
        st_q  <= enabled ? WWD_ST_RUN : WWD_ST_OFF;
      end else if (!enabled) begin
        cnt_q <= '0;
        st_q  <= WWD_ST_OFF;
      end else if (cfg_apply) begin
        cnt_q <= '0;
        st_q  <= WWD_ST_RUN;
      end else begin
        case (st_q)
          WWD_ST_OFF: begin
            cnt_q <= '0;
            st_q  <= WWD_ST_RUN;
          end
          WWD_ST_RUN: begin
            if (clr_eff) begin
              cnt_q <= '0;
              if (win_mode) begin
                st_q <= WWD_ST_CLOSED;
              end
            end else if (tick) begin
              if (cnt_q == per_len - 14'h0001) begin
                sys_reset_req <= 1'b1;
                cnt_q         <= '0;
              end else begin
                cnt_q <= cnt_q + 14'h0001;
              end
            end
          end
          WWD_ST_CLOSED: begin
            if (clr_eff) begin
              sys_reset_req <= 1'b1;
              cnt_q         <= '0;
              st_q          <= WWD_ST_RUN;
            end else if (tick) begin
              if (cnt_q == win_len - 14'h0001) begin
                cnt_q <= '0;
                st_q  <= WWD_ST_OPEN;
              end else begin
                cnt_q <= cnt_q + 14'h0001;
              end
            end
          end
          WWD_ST_OPEN: begin
            if (clr_eff) begin
              cnt_q <= '0;
              st_q  <= WWD_ST_CLOSED;
            end else if (tick) begin
              if (cnt_q == per_len - 14'h0001) begin
                sys_reset_req <= 1'b1;
                cnt_q         <= '0;
                st_q          <= WWD_ST_RUN;
              end else begin
                cnt_q <= cnt_q + 14'h0001;
              end
            end
          end
          default: begin
            cnt_q <= '0;
            st_q  <= WWD_ST_OFF;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    rd_mux = `WWD_RDATA_IDLE;
    if (sel_ctrl) begin
      rd_mux = ctrl_q;
    end else if (sel_stat) begin
      rd_mux = `WWD_STAT_RESET;
      rd_mux[`WWD_LOCK_BIT] = lock_q;
      rd_mux[`WWD_BUSY_BIT] = busy_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= `WWD_RDATA_IDLE;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : `WWD_RDATA_IDLE;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_reset_single_pulse: assert property (sys_reset_req |=> !sys_reset_req)
    else $error("reset request longer than one cycle");

  a_closed_clear_reset: assert property (
    (st_q == WWD_ST_CLOSED) && clr_eff && !dbg_halt && enabled && !cfg_apply
    |=> sys_reset_req)
    else $error("clear in closed period did not reset");

  a_normal_timeout: assert property (
    (st_q == WWD_ST_RUN) && tick && !clr_eff && !dbg_halt && !cfg_apply && enabled
    && (cnt_q == per_len - 14'h0001) |=> sys_reset_req && (cnt_q == '0))
    else $error("missed time-out in normal period");

  a_disabled_idle: assert property (
    !enabled && !dbg_halt |=> (st_q == WWD_ST_OFF) && !sys_reset_req)
    else $error("disabled watchdog not idle");

  a_halt_clears_cnt: assert property (dbg_halt |=> (cnt_q == '0) && !sys_reset_req)
    else $error("debug halt did not clear counter");

  a_resume_normal: assert property (
    dbg_halt && enabled ##1 !dbg_halt |-> (st_q == WWD_ST_RUN))
    else $error("resume did not start normal period");

  a_clear_restarts: assert property (
    clr_eff && (st_q == WWD_ST_RUN) && enabled && !dbg_halt && !cfg_apply
    |=> (cnt_q == '0) && !sys_reset_req)
    else $error("clear did not restart count");

  a_busy_on_write: assert property (wr_ctrl_ok |=> busy_q ##1 busy_q)
    else $error("busy flag not raised by write");

  a_locked_ctrl: assert property (
    lock_q && reg_wr && sel_ctrl |=> $stable(ctrl_q))
    else $error("locked control register changed");

  a_no_key_stable: assert property (
    !io_unlock_key |=> $stable(ctrl_q) && $stable(lock_q))
    else $error("protected bits changed without unlock");

  a_clear_delay: assert property (
    $rose(clr_pend_q) |-> !clr_eff [*2])
    else $error("clear acted too early");

  c_window_open_clear: cover property (
    (st_q == WWD_ST_OPEN) && clr_eff ##1 (st_q == WWD_ST_CLOSED));
  c_normal_timeout: cover property ((st_q == WWD_ST_RUN) ##1 sys_reset_req);
  c_debug_resume: cover property (dbg_halt ##1 !dbg_halt && (st_q == WWD_ST_RUN));
  c_cfg_applied: cover property (busy_q ##1 !busy_q);

endmodule // wwd_top

/* File: bench/wwd_core_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Core and reset controller model
// ----------------------------------------
module wwd_core_model (
  input  wire logic clk_sys,
  input  wire logic sys_reset_req,
  output logic      watchdog_tick_clock,
  output logic      watchdog_clear_instruction,
  output int        reset_count
);
  initial begin
    watchdog_tick_clock        = 1'b0;
    watchdog_clear_instruction = 1'b0;
    reset_count                = 0;
  end

  // Free-running oscillator, scaled fast and unrelated in phase
  always #803 watchdog_tick_clock = ~watchdog_tick_clock;

  // Reset controller counts request pulses
  always @(posedge clk_sys) begin
    if (sys_reset_req === 1'b1) reset_count <= reset_count + 1;
  end

  // One-cycle clear instruction
  task automatic clear_pulse();
    @(posedge clk_sys) watchdog_clear_instruction <= 1'b1;
    @(posedge clk_sys) watchdog_clear_instruction <= 1'b0;
  endtask
endmodule // wwd_core_model

/* File: bench/test_windowed_watchdog_timer.sv */
`timescale 1ns/1ps
`include "wwd_defines.svh"

module test_windowed_watchdog_timer;
  import wwd_pkg::*;
  logic      clk_sys, rst, tick, clr, io_unlock_key, dbg_halt, dbg_mode;
  logic      reg_wr, reg_rd, sys_reset_req;
  logic [7:0] reg_addr;
  wwd_byte_t reg_wdata, reg_rdata, rv, fuse;
  int        num_errors, checks, cnt, base;

  // ----------------------------------------
  // Clock, model and design
  // ----------------------------------------
  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  wwd_core_model u_wwd_core_model (.clk_sys(clk_sys), .sys_reset_req(sys_reset_req),
    .watchdog_tick_clock(tick), .watchdog_clear_instruction(clr), .reset_count(cnt));

  wwd_top u_wwd_top (.clk_sys(clk_sys), .rst(rst), .watchdog_tick_clock(tick),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .io_unlock_key(io_unlock_key),
    .watchdog_clear_instruction(clr), .dbg_halt(dbg_halt), .dbg_mode(dbg_mode),
    .fuse_watchdog_config(fuse), .sys_reset_req(sys_reset_req));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(string name, wwd_byte_t seen, wwd_byte_t exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, wwd_byte_t d, logic key);
    @(posedge clk_sys);
    reg_wr        <= 1'b1;
    reg_addr      <= a;
    reg_wdata     <= d;
    io_unlock_key <= key;
    @(posedge clk_sys);
    reg_wr        <= 1'b0;
    io_unlock_key <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  task automatic rd_chk(string name, logic [7:0] a, wwd_byte_t exp);
    rd(a);
    check(name, rv, exp);
  endtask

  task automatic wait_idle();
    rv = 8'h01;
    for (int i = 0; i < 20 && rv[`WWD_BUSY_BIT] !== 1'b0; i++) rd(`WWD_OFS_STAT);
    check("busy", rv & 8'h01, 8'h00);
  endtask

  task automatic ticks(int n);
    repeat (n) @(posedge tick);
  endtask

  task automatic resets(string name, int exp);
    check(name, 8'(cnt - base), 8'(exp));
    base = cnt;
  endtask

  task automatic print_verdict();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    io_unlock_key = 1'b0; dbg_halt = 1'b0; dbg_mode = 1'b0; fuse = 8'h00;
    num_errors = 0; checks = 0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk("ctrl", `WWD_OFS_CTRL, 8'h00);
    rd_chk("stat", `WWD_OFS_STAT, 8'h00);
    rd_chk("unmapped", 8'h05, 8'h00);
    wr(`WWD_OFS_CTRL, 8'h01, 1'b0);
    rd_chk("ctrl", `WWD_OFS_CTRL, 8'h00);
    $display("test reset and protection done");
    wr(`WWD_OFS_CTRL, 8'h01, 1'b1);
    rd_chk("stat", `WWD_OFS_STAT, 8'h01);
    rd_chk("ctrl", `WWD_OFS_CTRL, 8'h01);
    wait_idle();
    base = cnt;
    repeat (6) begin
      u_wwd_core_model.clear_pulse();
      ticks(4);
    end
    resets("resets", 0);
    ticks(20);
    resets("resets", 2);
    $display("test normal mode done");
    wr(`WWD_OFS_CTRL, 8'h11, 1'b1);
    wait_idle();
    base = cnt;
    u_wwd_core_model.clear_pulse();
    ticks(4);
    resets("resets", 0);
    u_wwd_core_model.clear_pulse();
    ticks(4);
    resets("resets", 1);
    repeat (4) begin
      u_wwd_core_model.clear_pulse();
      ticks(12);
    end
    resets("resets", 0);
    $display("test window mode done");
    wr(`WWD_OFS_STAT, 8'h80, 1'b0);
    rd_chk("stat", `WWD_OFS_STAT, 8'h00);
    wr(`WWD_OFS_STAT, 8'h80, 1'b1);
    rd_chk("stat", `WWD_OFS_STAT, 8'h80);
    wr(`WWD_OFS_CTRL, 8'h00, 1'b1);
    rd_chk("ctrl", `WWD_OFS_CTRL, 8'h11);
    wr(`WWD_OFS_STAT, 8'h00, 1'b1);
    rd_chk("stat", `WWD_OFS_STAT, 8'h80);
    @(posedge clk_sys) dbg_mode <= 1'b1;
    wr(`WWD_OFS_STAT, 8'h00, 1'b1);
    rd_chk("stat", `WWD_OFS_STAT, 8'h00);
    @(posedge clk_sys) dbg_mode <= 1'b0;
    $display("test lock done");
    u_wwd_core_model.clear_pulse();
    ticks(4);
    @(posedge clk_sys) dbg_halt <= 1'b1;
    ticks(2);
    base = cnt;
    ticks(24);
    resets("resets", 0);
    @(posedge clk_sys) dbg_halt <= 1'b0;
    ticks(12);
    resets("resets", 1);
    $display("test debug halt done");
    @(posedge clk_sys);
    rst  <= 1'b1;
    fuse <= 8'h02;
    repeat (10) @(posedge clk_sys);
    rst  <= 1'b0;
    base = cnt;
    rd_chk("ctrl", `WWD_OFS_CTRL, 8'h02);
    rd_chk("stat", `WWD_OFS_STAT, 8'h80);
    wr(`WWD_OFS_CTRL, 8'h00, 1'b1);
    rd_chk("ctrl", `WWD_OFS_CTRL, 8'h02);
    ticks(12);
    resets("resets", 0);
    ticks(8);
    resets("resets", 1);
    $display("test fuse reset done");
    print_verdict();
  end

  // Watchdog for a hung run
  initial begin
    #3000000;
    num_errors++;
    print_verdict();
  end
endmodule // test_windowed_watchdog_timer
